// ==== hdl/acr_params.svh ====
// Register selects, field positions, reset values and lengths for the register bank
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// ==========================================================
// Register selects
`define ACR_RSEL_STATUS 3'h0
`define ACR_RSEL_DATA 3'h3
`define ACR_RSEL_ID 3'h4
`define ACR_RSEL_GPO 3'h5

// ==========================================================
// Reset values
`define ACR_RESULT_RST 24'h00_0000
`define ACR_GPO_RST 8'h00

// Part code, arbitrary value
`define ACR_ID_PART_CODE 4'hA

// ==========================================================
// Status fields
`define ACR_STAT_READY_N_BIT 7
`define ACR_STAT_CHAN_LSB 0

// General output control fields
`define ACR_GPO_UPPER_EN_BIT 5
`define ACR_GPO_LOWER_EN_BIT 4

// ==========================================================
// Serial lengths in bits
`define ACR_LEN_BYTE 6'd8
`define ACR_LEN_RESULT 6'd24
`define ACR_LEN_RESULT_STAT 6'd32

`endif

// ==== hdl/acr_pkg.sv ====
// Types shared by the register bank modules
package acr_pkg;

  typedef logic [2:0] acr_rsel_t;
  typedef logic [3:0] acr_chan_t;

  typedef enum logic [2:0] {
    ACR_IDLE = 3'b001,
    ACR_SHIFT_OUT = 3'b010,
    ACR_SHIFT_IN = 3'b100
  } acr_state_e;

endpackage

// ==== hdl/acr_chan_decode.sv ====
// Channel-select decoder for differential and pseudo differential inputs
`timescale 1ns/1ns
module acr_chan_decode (
  input wire logic [7:0] channel_select,
  input wire logic pseudo_mode,
  output acr_pkg::acr_chan_t pos_input,
  output acr_pkg::acr_chan_t neg_input,
  output logic neg_common,
  output acr_pkg::acr_chan_t chan_code
);
  import acr_pkg::*;

  // Code n selects analog input n
  assign pos_input = channel_select[7:4];
  assign neg_input = pseudo_mode ? 4'h0 : channel_select[3:0];
  assign neg_common = pseudo_mode;
  assign chan_code = channel_select[7:4];

endmodule

// ==== hdl/acr_reg_bank.sv ====
// Register bank: channel decode, result, identification and general output control
`timescale 1ns/1ns
`include "acr_params.svh"
module acr_reg_bank (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] channel_select,
  input wire logic pseudo_mode,
  input wire logic append_status_enable,
  input wire logic conv_done,
  input wire logic [23:0] conv_data,
  input wire acr_pkg::acr_rsel_t register_select,
  input wire logic read_start,
  input wire logic write_start,
  input wire logic sdi,
  input wire logic sdi_valid,
  input wire logic [3:0] gp_in,
  output logic sdo,
  output logic sdo_valid,
  output logic read_done,
  output logic write_done,
  output logic busy,
  output logic ready_n,
  output acr_pkg::acr_chan_t pos_input,
  output acr_pkg::acr_chan_t neg_input,
  output logic neg_common,
  output logic [3:0] gp_out,
  output logic [3:0] gp_oe,
  output logic upper_pins_analog
);
  import acr_pkg::*;

  // ==========================================================
  // Channel decode
  acr_chan_t dec_pos;
  acr_chan_t dec_neg;
  logic dec_common;
  acr_chan_t dec_code;

  acr_chan_decode u_decode (
    .channel_select(channel_select),
    .pseudo_mode(pseudo_mode),
    .pos_input(dec_pos),
    .neg_input(dec_neg),
    .neg_common(dec_common),
    .chan_code(dec_code)
  );

  acr_chan_t channel_indicator;

  always_ff @(posedge clk) begin
    if (srst) begin
      pos_input <= 4'h0;
      neg_input <= 4'h0;
      neg_common <= 1'b0;
    end else begin
      pos_input <= dec_pos;
      neg_input <= dec_neg;
      neg_common <= dec_common;
    end
  end

  // ==========================================================
  // Conversion result and ready flag
  logic [23:0] result;
  acr_state_e state;
  acr_rsel_t cur_sel;
  logic [5:0] cnt;
  logic [31:0] shreg;
  logic [7:0] shin;
  logic [7:0] gpo;

  wire data_read_done = read_done && (cur_sel == `ACR_RSEL_DATA);

  always_ff @(posedge clk) begin
    if (srst) begin
      result <= `ACR_RESULT_RST;
      channel_indicator <= 4'h0;
      ready_n <= 1'b1;
    end else begin
      if (conv_done) begin
        result <= conv_data;
        channel_indicator <= dec_code;
        ready_n <= 1'b0;
      end else if (data_read_done) begin
        ready_n <= 1'b1;
      end
    end
  end

  wire [7:0] status_word = {ready_n, 3'b000, channel_indicator};
  wire [7:0] id_word = {4'h0, `ACR_ID_PART_CODE};

  // ==========================================================
  // General output control
  wire upper_en = gpo[`ACR_GPO_UPPER_EN_BIT];
  wire lower_en = gpo[`ACR_GPO_LOWER_EN_BIT];
  wire [1:0] upper_levels = upper_en ? gp_in[3:2] : gpo[3:2];
  wire [1:0] lower_levels = lower_en ? gp_in[1:0] : gpo[1:0];
  wire [7:0] gpo_read = {2'b00, gpo[5:4], upper_levels, lower_levels};

  assign gp_oe = {upper_en, upper_en, lower_en, lower_en};
  assign gp_out = gpo[3:0] & gp_oe;
  assign upper_pins_analog = ~upper_en;

  // ==========================================================
  // Serial shift engine
  wire start_rd = (state == ACR_IDLE) && read_start;
  wire start_wr = (state == ACR_IDLE) && write_start && !read_start;
  wire sel_data = register_select == `ACR_RSEL_DATA;
  wire [31:0] data_word = append_status_enable ? {result, status_word} : {result, 8'h00};
  wire [31:0] load_word = sel_data ? data_word :
    (register_select == `ACR_RSEL_ID) ? {id_word, 24'h00_0000} :
    (register_select == `ACR_RSEL_GPO) ? {gpo_read, 24'h00_0000} :
    (register_select == `ACR_RSEL_STATUS) ? {status_word, 24'h00_0000} : 32'h0000_0000;
  wire [5:0] load_len = !sel_data ? `ACR_LEN_BYTE :
    append_status_enable ? `ACR_LEN_RESULT_STAT : `ACR_LEN_RESULT;
  wire [7:0] next_byte = {shin[6:0], sdi};
  wire last_in = (state == ACR_SHIFT_IN) && sdi_valid && (cnt == 6'd1);

  assign sdo = shreg[31];
  assign sdo_valid = state == ACR_SHIFT_OUT;
  assign read_done = (state == ACR_SHIFT_OUT) && (cnt == 6'd1);
  assign write_done = last_in;
  assign busy = state != ACR_IDLE;

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ACR_IDLE;
      cur_sel <= 3'h0;
      cnt <= 6'd0;
      shreg <= 32'h0000_0000;
      shin <= 8'h00;
    end else begin
      case (state)
        ACR_IDLE: begin
          if (start_rd) begin
            state <= ACR_SHIFT_OUT;
            cur_sel <= register_select;
            cnt <= load_len;
            shreg <= load_word;
          end else if (start_wr) begin
            state <= ACR_SHIFT_IN;
            cur_sel <= register_select;
            cnt <= `ACR_LEN_BYTE;
          end
        end
        ACR_SHIFT_OUT: begin
          shreg <= {shreg[30:0], 1'b0};
          cnt <= cnt - 6'd1;
          if (cnt == 6'd1) begin
            state <= ACR_IDLE;
          end
        end
        ACR_SHIFT_IN: begin
          if (sdi_valid) begin
            shin <= next_byte;
            cnt <= cnt - 6'd1;
            if (cnt == 6'd1) begin
              state <= ACR_IDLE;
            end
          end
        end
        default: begin
          state <= ACR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gpo <= `ACR_GPO_RST;
    end else if (last_in && (cur_sel == `ACR_RSEL_GPO)) begin
      gpo <= {2'b00, next_byte[5:0]};
    end
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_result_load: assert property (conv_done |=> result == $past(conv_data))
    else $error("result not loaded from conversion");
  a_result_hold: assert property (!conv_done |=> $stable(result))
    else $error("result changed without a conversion");
  a_ready_after_read: assert property (data_read_done && !conv_done |=> ready_n)
    else $error("ready not cleared after result read");
  a_append_length: assert property (start_rd && sel_data && append_status_enable |-> ##32 read_done)
    else $error("appended read not 32 bits long");
  a_plain_length: assert property (start_rd && sel_data && !append_status_enable |-> ##24 read_done)
    else $error("result read not 24 bits long");
  a_status_chan: assert property (conv_done |=> status_word[3:0] == $past(channel_select[7:4]))
    else $error("channel indicator wrong");
  a_diff_neg: assert property (!pseudo_mode |=> !neg_common && neg_input == $past(channel_select[3:0]))
    else $error("differential negative input wrong");
  a_pseudo_pos: assert property (pseudo_mode |=> neg_common && pos_input == $past(channel_select[7:4]))
    else $error("pseudo positive input wrong");
  a_gpo_msb_first: assert property (start_rd && register_select == `ACR_RSEL_GPO |=>
    sdo == $past(gpo_read[7]) ##1 sdo == $past(gpo_read[6], 2) ##1 sdo == $past(gpo_read[5], 3))
    else $error("output control not sent msb first");
  a_gpo_top_zero: assert property (gpo[7:6] == 2'b00)
    else $error("top output control bits not zero");
  a_lower_ignored: assert property (!lower_en |-> gp_out[1:0] == 2'b00 && gp_oe[1:0] == 2'b00)
    else $error("lower pair driven while disabled");
  a_gpo_write: assert property (last_in && cur_sel == `ACR_RSEL_GPO |=> gpo[5:0] == $past(next_byte[5:0]))
    else $error("output control write lost");

endmodule

// ==== tb/acr_host_model.sv ====
// Host model driving register reads and writes on the serial port
`timescale 1ns/1ns
module acr_host_model (
  input wire logic clk,
  input wire logic sdo,
  output logic read_start,
  output logic write_start,
  output acr_pkg::acr_rsel_t register_select,
  output logic sdi,
  output logic sdi_valid
);
  import acr_pkg::*;
  initial begin
    read_start = 1'b0;
    write_start = 1'b0;
    register_select = 3'h0;
    sdi = 1'b0;
    sdi_valid = 1'b0;
  end
  // ==========================================
  // Read n bits, first bit lands in bit n-1
  task automatic rd(input acr_rsel_t sel, input int n, output logic [31:0] d);
    d = '0;
    @(posedge clk) #2;
    register_select = sel;
    read_start = 1'b1;
    @(posedge clk) #2;
    read_start = 1'b0;
    register_select = ~sel;
    repeat (n) begin
      @(negedge clk);
      d = {d[30:0], sdo};
    end
    @(posedge clk) #2;
  endtask
  // ==========================================
  // Write one byte, top bit first
  task automatic wr(input acr_rsel_t sel, input logic [7:0] v);
    logic [7:0] b;
    b = {2'b00, v[5:0]};
    @(posedge clk) #2;
    register_select = sel;
    write_start = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) #2;
      write_start = 1'b0;
      sdi_valid = 1'b1;
      sdi = b[i];
    end
    @(posedge clk) #2;
    sdi_valid = 1'b0;
    sdi = ~sdi;
  endtask
endmodule

// ==== tb/acr_reg_bank_tb.sv ====
// Self-checking bench for the register bank
`timescale 1ns/1ns
`include "acr_params.svh"
module acr_reg_bank_tb;
  import acr_pkg::*;
  typedef struct {logic [7:0] cs; logic pm; logic [3:0] p; logic [3:0] n; logic nc;} acr_row_s;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] channel_select = 8'h00;
  logic pseudo_mode = 1'b0;
  logic append_status_enable = 1'b0;
  logic conv_done = 1'b0;
  logic [23:0] conv_data = 24'h00_0000;
  logic [3:0] gp_in = 4'h9;
  logic read_start, write_start, sdi, sdi_valid, sdo, sdo_valid, read_done, write_done, busy;
  logic ready_n, neg_common, upper_pins_analog;
  logic [3:0] gp_out, gp_oe;
  acr_rsel_t register_select;
  acr_chan_t pos_input, neg_input;
  logic [31:0] d;
  int errors = 0;
  int total_checks = 0;
  int n_valid = 0;
  int n_rdone = 0;
  int n_wdone = 0;
  int n_busy = 0;
  acr_row_s rows [6] = '{'{8'h3A, 0, 4'h3, 4'hA, 0}, '{8'hF0, 0, 4'hF, 4'h0, 0},
    '{8'h0F, 0, 4'h0, 4'hF, 0}, '{8'h5C, 1, 4'h5, 4'h0, 1}, '{8'hFF, 1, 4'hF, 4'h0, 1},
    '{8'h07, 1, 4'h0, 4'h0, 1}};
  always #10 clk = ~clk;
  // Handshake activity, sampled mid cycle
  always @(negedge clk) begin
    if (srst === 1'b0) begin
      if (sdo_valid === 1'b1) n_valid++;
      if (read_done === 1'b1) n_rdone++;
      if (write_done === 1'b1) n_wdone++;
      if (busy === 1'b1) n_busy++;
    end
  end
  acr_reg_bank DUT (.clk, .srst, .channel_select, .pseudo_mode, .append_status_enable, .conv_done,
    .conv_data, .register_select, .read_start, .write_start, .sdi, .sdi_valid, .gp_in, .sdo,
    .sdo_valid, .read_done, .write_done, .busy, .ready_n, .pos_input, .neg_input, .neg_common,
    .gp_out, .gp_oe, .upper_pins_analog);
  acr_host_model host (.clk, .sdo, .read_start, .write_start, .register_select, .sdi, .sdi_valid);
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conv(input logic [23:0] v);
    @(posedge clk) #2;
    conv_data = v;
    conv_done = 1'b1;
    @(posedge clk) #2;
    conv_done = 1'b0;
    conv_data = ~v;
  endtask
  task automatic gpo(input logic [7:0] v, input logic [3:0] oe, input logic [3:0] o,
    input logic ua, input logic [7:0] rb);
    host.wr(`ACR_RSEL_GPO, v);
    chk(gp_oe, oe);
    chk(gp_out, o);
    chk(upper_pins_analog, ua);
    host.rd(`ACR_RSEL_GPO, 8, d);
    chk(d, rb);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #2 srst = 1'b0;
    chk(ready_n, 1);
    chk(gp_oe, 0);
    host.rd(`ACR_RSEL_DATA, 24, d);
    chk(d, `ACR_RESULT_RST);
    host.rd(`ACR_RSEL_GPO, 8, d);
    chk(d, `ACR_GPO_RST);
    foreach (rows[i]) begin
      channel_select = rows[i].cs;
      pseudo_mode = rows[i].pm;
      conv(24'h00_0100 + 24'(i));
      chk(pos_input, rows[i].p);
      chk(neg_input, rows[i].n);
      chk(neg_common, rows[i].nc);
      host.rd(`ACR_RSEL_STATUS, 8, d);
      chk(d, {28'h0, rows[i].cs[7:4]});
    end
    channel_select = 8'h7E;
    pseudo_mode = 1'b0;
    conv(24'hA5_C396);
    chk(ready_n, 0);
    append_status_enable = 1'b1;
    host.rd(`ACR_RSEL_DATA, 32, d);
    chk(d, {24'hA5_C396, 8'h07});
    chk(ready_n, 1);
    append_status_enable = 1'b0;
    host.wr(`ACR_RSEL_DATA, 8'h00);
    host.rd(`ACR_RSEL_DATA, 24, d);
    chk(d, 32'h00A5_C396);
    gpo(8'hFF, 4'hF, 4'hF, 1'b0, 8'h39);
    gpo(8'h1A, 4'h3, 4'h2, 1'b1, 8'h19);
    gpo(8'h25, 4'hC, 4'h4, 1'b0, 8'h29);
    host.rd(`ACR_RSEL_ID, 8, d);
    chk(d, {28'h0, `ACR_ID_PART_CODE});
    host.wr(`ACR_RSEL_ID, 8'h00);
    chk(gp_oe, 4'hC);
    // Mid-run reset clears result, ready flag and output control
    conv(24'h12_3456);
    @(posedge clk) #2;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #2 srst = 1'b0;
    chk(ready_n, 1);
    chk(gp_oe, 0);
    chk(upper_pins_analog, 1);
    host.rd(`ACR_RSEL_DATA, 24, d);
    chk(d, `ACR_RESULT_RST);
    host.rd(`ACR_RSEL_GPO, 8, d);
    chk(d, `ACR_GPO_RST);
    // Bit, done and busy cycles summed over every transfer above
    chk(n_valid, 200);
    chk(n_rdone, 16);
    chk(n_wdone, 5);
    chk(n_busy, 240);
    close_out();
  end
  initial begin
    #200000;
    errors++;
    close_out();
  end
endmodule
